//--- verilog/tsc_pkg.sv
// Constants for the video switch configuration register bank.
// Assumes a 10 MHz system clock and a byte-wide register write port.
`default_nettype none
package tsc_pkg;
    // ==========================================
    // Register addresses
    localparam logic [7:0] ADDR_HS_MODE = 8'h00;
    localparam logic [7:0] ADDR_AUX_MODE = 8'h01;
    localparam logic [7:0] ADDR_RX_SET = 8'h10;
    localparam logic [7:0] ADDR_TERM_PULSE = 8'h11;
    localparam logic [7:0] ADDR_EQUALIZE_LEVEL_MASK = 8'h13;
    localparam logic [7:0] ADDR_TX_SET = 8'h20;
    // ==========================================
    // Reset values
    localparam logic [7:0] RST_HS_MODE = 8'h40;
    localparam logic [7:0] RST_AUX_MODE = 8'h40;
    localparam logic [7:0] RST_RX_SET = 8'h01;
    localparam logic [7:0] RST_TERM_PULSE = 8'h00;
    localparam logic [7:0] RST_EQUALIZE_LEVEL_MASK = 8'h00;
    localparam logic [7:0] RST_TX_SET = 8'h03;
    // ==========================================
    // Field positions
    localparam int BIT_ENABLE = 6;
    localparam int BIT_SOURCE = 0;
    localparam int BIT_IN_TERM = 0;
    localparam int BIT_DRIVE = 0;
    localparam int BIT_OUT_TERM = 1;
    localparam int POS_PREEMPH = 2;
    localparam int NUM_REGS = 6;
    // ==========================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_MS = 100;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
    localparam int UPDATE_US = 10;
    localparam int UPDATE_CYCLES = CLK_HZ / 1_000_000 * UPDATE_US;
endpackage : tsc_pkg
`default_nettype wire

//--- verilog/tsc_reg_store.sv
// Six-entry register memory with registered read data.
// Assumes one write or one read per cycle from the owning bank.
`default_nettype none
module tsc_reg_store
    import tsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [8*NUM_REGS-1:0] all_q
);
    logic [7:0] mem_q [NUM_REGS];

    function automatic logic [7:0] reset_of(input int idx);
        case (idx)
            0: reset_of = RST_HS_MODE;
            1: reset_of = RST_AUX_MODE;
            2: reset_of = RST_RX_SET;
            3: reset_of = RST_TERM_PULSE;
            4: reset_of = RST_EQUALIZE_LEVEL_MASK;
            default: reset_of = RST_TX_SET;
        endcase
    endfunction : reset_of

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_reg
            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    mem_q[g] <= reset_of(g);
                else if (wr_en && wr_idx == 3'(g))
                    mem_q[g] <= wr_data;
            end
            assign all_q[8*g +: 8] = mem_q[g];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rd_data <= 8'h00;
        else if (rd_idx < 3'(NUM_REGS))
            rd_data <= mem_q[rd_idx];
        else
            rd_data <= 8'h00;
    end
endmodule : tsc_reg_store
`default_nettype wire

//--- verilog/tsc_pulse_timer.sv
// Termination pulse timer for one source change.
// Assumes start is a one-cycle pulse in the system clock domain.
`default_nettype none
module tsc_pulse_timer
    import tsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic start,
    output logic busy
);
    logic [20:0] cnt_q;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            cnt_q <= 21'h0;
            busy <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= 21'(PULSE_CYCLES - 1);
            busy <= 1'b1;
        end
        else if (cnt_q != 21'h0)
            cnt_q <= cnt_q - 21'h1;
        else
            busy <= 1'b0;
    end
endmodule : tsc_pulse_timer
`default_nettype wire

//--- verilog/tsc_config_regs.sv
// Configuration register bank of a two-input video lane switch.
// Assumes a serial bus front end that delivers decoded byte writes and reads.
// Notes on behaviour
// - Enable bit 0 turns lanes off and enters standby; 1 turns lanes on.
// - Source select 0 routes group A to outputs, 1 routes group B.
// - Auxiliary enable 0 disconnects low-speed lines; 1 lets the switch conduct.
// - Auxiliary select 0 connects group A side lines, 1 group B.
// - Input termination bit 0 disconnects terminations, 1 connects them.
// - Termination pulsing happens only with input termination on, per lane mask.
// - Masked lane termination drops for about 100 ms on each source change.
// - Unmasked lane keeps its termination connected through a source change.
// - Pulse bits 0..3 map to A0..A3, bits 4..7 map to B3..B0.
// - Equalize bit 0 selects 6 dB, 1 selects 12 dB for its lane.
// - Equalize bits map to lanes with the same ordering as pulse bits.
// - Two-bit preemphasis gives 0, 2, 4 or 6 dB on all lanes.
// - Output termination bit 0 disables, 1 enables all output terminations.
// - Drive current bit 0 gives 10 mA, 1 gives 20 mA.
// - Writes inside an update window do not restart it; last value applies.
`default_nettype none
module tsc_config_regs
    import tsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic lane_switch_on,
    output logic lane_standby,
    output logic lane_source_sel,
    output logic side_switch_on,
    output logic side_source_sel,
    output logic input_term_on,
    output logic [3:0] term_conn_a,
    output logic [3:0] term_conn_b,
    output logic [3:0] eq_high_a,
    output logic [3:0] eq_high_b,
    output logic [1:0] preemphasis_level,
    output logic output_term_on,
    output logic drive_current_sel
);
    // ==========================================
    // Reset release
    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // ==========================================
    // Address decode
    function automatic logic [3:0] addr_index(input logic [7:0] a);
        if (a == ADDR_HS_MODE)
            addr_index = 4'h0;
        else if (a == ADDR_AUX_MODE)
            addr_index = 4'h1;
        else if (a == ADDR_RX_SET)
            addr_index = 4'h2;
        else if (a == ADDR_TERM_PULSE)
            addr_index = 4'h3;
        else if (a == ADDR_EQUALIZE_LEVEL_MASK)
            addr_index = 4'h4;
        else if (a == ADDR_TX_SET)
            addr_index = 4'h5;
        else
            addr_index = 4'h7;
    endfunction : addr_index

    logic [3:0] wr_sel;
    logic [3:0] rd_sel;
    logic wr_hit;
    logic [8*NUM_REGS-1:0] regs_all;
    logic [7:0] store_rdata;

    assign wr_sel = addr_index(reg_addr);
    assign rd_sel = addr_index(reg_addr);
    assign wr_hit = wr_stb && (wr_sel != 4'h7);

    tsc_reg_store u_store (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .wr_en(wr_hit),
        .wr_idx(wr_sel[2:0]),
        .wr_data(reg_wdata),
        .rd_idx(rd_stb ? rd_sel[2:0] : 3'h7),
        .rd_data(store_rdata),
        .all_q(regs_all)
    );

    // Read data: unmapped addresses read as zero
    always_comb
    begin
        reg_rdata = store_rdata;
    end

    // ==========================================
    // Update windows, one per register
    logic [NUM_REGS-1:0] win_busy;
    logic [NUM_REGS-1:0] pend_q;
    logic [7:0] applied_q [NUM_REGS];
    logic [15:0] win_cnt_q [NUM_REGS];

    function automatic logic [7:0] reset_value(input int idx);
        case (idx)
            0: reset_value = RST_HS_MODE;
            1: reset_value = RST_AUX_MODE;
            2: reset_value = RST_RX_SET;
            3: reset_value = RST_TERM_PULSE;
            4: reset_value = RST_EQUALIZE_LEVEL_MASK;
            default: reset_value = RST_TX_SET;
        endcase
    endfunction : reset_value

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_win
            logic wr_this;
            assign wr_this = wr_hit && (wr_sel == 4'(g));
            assign win_busy[g] = (win_cnt_q[g] != 16'h0);

            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    win_cnt_q[g] <= 16'h0;
                else if (win_busy[g])
                    win_cnt_q[g] <= win_cnt_q[g] - 16'h1;
                else if (wr_this || pend_q[g])
                    win_cnt_q[g] <= 16'(UPDATE_CYCLES);
            end

            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    pend_q[g] <= 1'b0;
                else if (wr_this && win_busy[g])
                    pend_q[g] <= 1'b1;
                else if (!win_busy[g])
                    pend_q[g] <= 1'b0;
            end

            // Apply immediately when idle, or the newest value when window ends
            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    applied_q[g] <= reset_value(g);
                else if (wr_this && !win_busy[g])
                    applied_q[g] <= reg_wdata;
                else if (pend_q[g] && !win_busy[g])
                    applied_q[g] <= regs_all[8*g +: 8];
            end
        end
    endgenerate

    // ==========================================
    // Source change detection and termination pulse
    logic src_prev_q;
    logic pulse_start;
    logic pulse_busy;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            src_prev_q <= RST_HS_MODE[BIT_SOURCE];
        else
            src_prev_q <= applied_q[0][BIT_SOURCE];
    end

    assign pulse_start = (src_prev_q != applied_q[0][BIT_SOURCE]);

    tsc_pulse_timer u_pulse (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .start(pulse_start),
        .busy(pulse_busy)
    );

    // Lane order of the mask bytes: bits 4..7 are B3..B0
    function automatic logic [3:0] b_lanes(input logic [7:0] m);
        b_lanes = {m[4], m[5], m[6], m[7]};
    endfunction : b_lanes

    // ==========================================
    // Output registers
    logic [7:0] hs_r;
    logic [7:0] aux_r;
    logic [7:0] rx_r;
    logic [7:0] pt_r;
    logic [7:0] eq_r;
    logic [7:0] tx_r;
    logic [3:0] drop_a;
    logic [3:0] drop_b;

    assign hs_r = applied_q[0];
    assign aux_r = applied_q[1];
    assign rx_r = applied_q[2];
    assign pt_r = applied_q[3];
    assign eq_r = applied_q[4];
    assign tx_r = applied_q[5];
    assign drop_a = (pulse_busy || pulse_start) ? pt_r[3:0] : 4'h0;
    assign drop_b = (pulse_busy || pulse_start) ? b_lanes(pt_r) : 4'h0;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            lane_switch_on <= RST_HS_MODE[BIT_ENABLE];
            lane_standby <= !RST_HS_MODE[BIT_ENABLE];
            lane_source_sel <= RST_HS_MODE[BIT_SOURCE];
        end
        else
        begin
            lane_switch_on <= hs_r[BIT_ENABLE];
            lane_standby <= !hs_r[BIT_ENABLE];
            lane_source_sel <= hs_r[BIT_SOURCE];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            side_switch_on <= RST_AUX_MODE[BIT_ENABLE];
            side_source_sel <= RST_AUX_MODE[BIT_SOURCE];
        end
        else
        begin
            side_switch_on <= aux_r[BIT_ENABLE];
            side_source_sel <= aux_r[BIT_SOURCE];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            input_term_on <= RST_RX_SET[BIT_IN_TERM];
            term_conn_a <= {4{RST_RX_SET[BIT_IN_TERM]}};
            term_conn_b <= {4{RST_RX_SET[BIT_IN_TERM]}};
        end
        else
        begin
            input_term_on <= rx_r[BIT_IN_TERM];
            term_conn_a <= {4{rx_r[BIT_IN_TERM]}} & ~drop_a;
            term_conn_b <= {4{rx_r[BIT_IN_TERM]}} & ~drop_b;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            eq_high_a <= RST_EQUALIZE_LEVEL_MASK[3:0];
            eq_high_b <= b_lanes(RST_EQUALIZE_LEVEL_MASK);
        end
        else
        begin
            eq_high_a <= eq_r[3:0];
            eq_high_b <= b_lanes(eq_r);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            preemphasis_level <= RST_TX_SET[POS_PREEMPH +: 2];
            output_term_on <= RST_TX_SET[BIT_OUT_TERM];
            drive_current_sel <= RST_TX_SET[BIT_DRIVE];
        end
        else
        begin
            preemphasis_level <= tx_r[POS_PREEMPH +: 2];
            output_term_on <= tx_r[BIT_OUT_TERM];
            drive_current_sel <= tx_r[BIT_DRIVE];
        end
    end

    // ==========================================
    // Checks
    sequence s_src_flip;
        applied_q[0][BIT_SOURCE] != src_prev_q;
    endsequence

    // Cycles since the current termination drop began
    logic [20:0] drop_len_q;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            drop_len_q <= 21'h0;
        else if (pulse_start)
            drop_len_q <= 21'h0;
        else if (pulse_busy)
            drop_len_q <= drop_len_q + 21'h1;
    end

    a_enable_standby: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        lane_switch_on != lane_standby)
        else $error("standby not inverse of enable");
    a_source_follow: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        ##1 lane_source_sel == $past(hs_r[BIT_SOURCE]))
        else $error("lane source does not follow applied value");
    a_aux_follow: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        ##1 side_switch_on == $past(aux_r[BIT_ENABLE]))
        else $error("aux enable does not follow applied value");
    a_side_select: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        ##1 side_source_sel == $past(aux_r[BIT_SOURCE]))
        else $error("aux source does not follow applied value");
    a_no_drop: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (!pulse_busy && !pulse_start)
        |=> (term_conn_a == {4{input_term_on}} && term_conn_b == {4{input_term_on}}))
        else $error("termination dropped outside a pulse");
    a_term_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        !input_term_on |-> (term_conn_a == 4'h0 && term_conn_b == 4'h0))
        else $error("termination connected while disabled");
    a_pulse_drop: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_src_flip and rx_r[BIT_IN_TERM] && pt_r[0] && $stable(rx_r) && $stable(pt_r))
        |=> !term_conn_a[0])
        else $error("masked lane not dropped on source change");
    a_pulse_length: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (pulse_busy && !pulse_start && drop_len_q < 21'(PULSE_CYCLES - 1)) |=> pulse_busy)
        else $error("termination pulse ended early");
    a_pulse_keep: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_src_flip and rx_r[BIT_IN_TERM] && !pt_r[7] && $stable(rx_r) && $stable(pt_r))
        |=> term_conn_b[0])
        else $error("unmasked lane dropped on source change");
    a_eq_order: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        ##1 eq_high_b[0] == $past(eq_r[7]))
        else $error("lane B0 equalizer not taken from mask bit 7");
    a_window_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (win_busy[5] && !pend_q[5]) |=> $stable(applied_q[5]))
        else $error("applied value changed inside window");
    a_pulse_cause: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        $rose(pulse_busy) |-> $past(pulse_start))
        else $error("pulse started without source change");
endmodule : tsc_config_regs
`default_nettype wire

//--- testbench/tsc_host_model.sv
// Host side of the register port: issues single byte writes and reads.
// Assumes the bench calls xfer only after reset has been released.
`default_nettype none
module tsc_host_model (
    input wire logic clk_sys,
    output var logic wr_stb,
    output var logic rd_stb,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy = 1'b0;
    initial
    begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        reg_addr = 8'h5a;
        reg_wdata = 8'ha5;
    end
    // ==========================================
    // Idle lines toggle so a stale value never looks like a request
    always @(posedge clk_sys)
    begin
        if (!busy)
        begin
            reg_addr <= ~reg_addr;
            reg_wdata <= ~reg_wdata;
        end
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        busy = 1'b1;
        @(posedge clk_sys);
        wr_stb <= wr;
        rd_stb <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        busy = 1'b0;
    endtask : xfer
endmodule : tsc_host_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the video switch configuration register bank.
// Assumes the host model drives the register port and the bench tracks state.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tsc_pkg::*;
    logic clk_sys;
    logic rst_n;
    logic wr_stb, rd_stb, lane_switch_on, lane_standby, lane_source_sel, side_switch_on;
    logic side_source_sel, input_term_on, output_term_on, drive_current_sel;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, hs, aux, rx, pm, eq, tx;
    logic [3:0] term_conn_a, term_conn_b, eq_high_a, eq_high_b;
    logic [1:0] preemphasis_level;
    logic rd_seen = 1'b0;
    int n_fail = 0;
    int cmp_count = 0;
    logic [7:0] exp_q[$];
    tsc_config_regs i_dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .lane_switch_on(lane_switch_on),
        .lane_standby(lane_standby),
        .lane_source_sel(lane_source_sel),
        .side_switch_on(side_switch_on),
        .side_source_sel(side_source_sel),
        .input_term_on(input_term_on),
        .term_conn_a(term_conn_a),
        .term_conn_b(term_conn_b),
        .eq_high_a(eq_high_a),
        .eq_high_b(eq_high_b),
        .preemphasis_level(preemphasis_level),
        .output_term_on(output_term_on),
        .drive_current_sel(drive_current_sel)
    );
    tsc_host_model i_host (
        .clk_sys(clk_sys),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ==========================================
    // Checking helpers
    task automatic end_sim;
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [3:0] rev(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev
    task automatic cfg_chk;
        chk({lane_switch_on, lane_standby, lane_source_sel, 5'h00},
            {hs[6], ~hs[6], hs[0], 5'h00});
        chk({side_switch_on, side_source_sel, input_term_on, 5'h00},
            {aux[6], aux[0], rx[0], 5'h00});
        chk({eq_high_b, eq_high_a}, {rev(eq[7:4]), eq[3:0]});
        chk({4'h0, preemphasis_level, output_term_on, drive_current_sel},
            {4'h0, tx[3:0]});
    endtask : cfg_chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'b0, a, 8'h00);
    endtask : rd
    task automatic set(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d);
        case (a)
            ADDR_HS_MODE: hs = d;
            ADDR_AUX_MODE: aux = d;
            ADDR_RX_SET: rx = d;
            ADDR_TERM_PULSE: pm = d;
            ADDR_EQUALIZE_LEVEL_MASK: eq = d;
            default: tx = d;
        endcase
        repeat (2) @(posedge clk_sys);
        #1;
        cfg_chk();
        rd(a, d);
        repeat (110) @(posedge clk_sys);
    endtask : set
    // ==========================================
    // Read monitor: data is due on the same edge that takes the strobe and is checked at the next falling edge
    always @(posedge clk_sys) rd_seen <= rd_stb;
    always @(negedge clk_sys)
    begin
        if (rd_seen)
            chk(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end
    // ==========================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        {hs, aux, rx} = {RST_HS_MODE, RST_AUX_MODE, RST_RX_SET};
        {pm, eq, tx} = {RST_TERM_PULSE, RST_EQUALIZE_LEVEL_MASK, RST_TX_SET};
        void'($urandom(56177));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        cfg_chk();
        rd(ADDR_HS_MODE, RST_HS_MODE);
        rd(ADDR_AUX_MODE, RST_AUX_MODE);
        rd(ADDR_RX_SET, RST_RX_SET);
        rd(ADDR_TERM_PULSE, RST_TERM_PULSE);
        rd(ADDR_EQUALIZE_LEVEL_MASK, RST_EQUALIZE_LEVEL_MASK);
        rd(ADDR_TX_SET, RST_TX_SET);
        set(ADDR_HS_MODE, 8'h00);
        set(ADDR_HS_MODE, 8'h40);
        set(ADDR_AUX_MODE, 8'h41);
        set(ADDR_AUX_MODE, 8'h00);
        set(ADDR_AUX_MODE, 8'h40);
        set(ADDR_RX_SET, 8'h00);
        for (int i = 0; i < 4; i++)
            set(ADDR_TX_SET, {4'h0, i[1:0], ~i[0], i[1]});
        set(ADDR_EQUALIZE_LEVEL_MASK, 8'h80);
        for (int i = 0; i < 3; i++)
            set(ADDR_EQUALIZE_LEVEL_MASK, 8'($urandom));
        // Unmapped address: no effect, reads as zero
        i_host.xfer(1'b1, 8'h12, 8'hff);
        repeat (2) @(posedge clk_sys);
        #1;
        cfg_chk();
        rd(8'h12, 8'h00);
        // Later writes inside the window wait for its end, newest wins
        i_host.xfer(1'b1, ADDR_TX_SET, 8'h00);
        tx = 8'h00;
        repeat (2) @(posedge clk_sys);
        #1;
        cfg_chk();
        repeat (10) @(posedge clk_sys);
        i_host.xfer(1'b1, ADDR_TX_SET, 8'h0c);
        repeat (10) @(posedge clk_sys);
        i_host.xfer(1'b1, ADDR_TX_SET, 8'h05);
        repeat (20) @(posedge clk_sys);
        #1;
        cfg_chk();
        tx = 8'h05;
        repeat (70) @(posedge clk_sys);
        #1;
        cfg_chk();
        rd(ADDR_TX_SET, 8'h05);
        repeat (110) @(posedge clk_sys);
        // Termination pulse on a real source change only
        // Lane A0 always masked and lane B0 never, so both lane checks see the change
        set(ADDR_TERM_PULSE, (8'($urandom) | 8'h11) & 8'h7f);
        set(ADDR_RX_SET, 8'h01);
        set(ADDR_HS_MODE, 8'h40);
        #1;
        chk({term_conn_b, term_conn_a}, 8'hff);
        i_host.xfer(1'b1, ADDR_HS_MODE, 8'h41);
        hs = 8'h41;
        repeat (2) @(posedge clk_sys);
        #1;
        cfg_chk();
        chk({term_conn_b, term_conn_a}, {~rev(pm[7:4]), ~pm[3:0]});
        repeat (1000) @(posedge clk_sys);
        #1;
        chk({term_conn_b, term_conn_a}, {~rev(pm[7:4]), ~pm[3:0]});
        end_sim();
    end
endmodule : tb
`default_nettype wire
